// ==== ssu_bus_model.sv ====
// Purpose: far-side serial bus device: clock source and data driver
// Assumes: open-drain lines with pull-ups, clock stands high outside frames
// Notes:   link clock phase unrelated to the system clock
module ssu_bus_model (
	input  wire logic run,
	input  wire logic sda_drv,
	input  wire logic scl_oe,
	input  wire logic scl_out,
	input  wire logic sda_oe,
	input  wire logic sda_out,
	output logic      scl_line,
	output logic      sda_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_drv = 1'b1;
	// Toggle each half period only within a frame, else release
	initial begin
		#7;
		forever begin
			#160;
			scl_drv = run ? ~scl_drv : 1'b1;
		end
	end
	// Wired-AND: any party pulling low wins over the pull-up
	assign scl_line = scl_drv & ~(scl_oe & ~scl_out);
	assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
endmodule : ssu_bus_model

// ==== ssu_ctl.sv ====
// Purpose: control, status, counter and pin logic of a serial shift unit
// Assumes: 25 MHz clk; pins asynchronous to clk, each clk cycle of timer_ovf high is one pulse
// Notes:   Avalon-MM slave, one wait state per access
module ssu_ctl
	import ssu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        timer_ovf,
	input  wire logic        global_irq_en,
	output logic             start_irq,
	output logic             overflow_irq,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             scl_pullup,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             sda_pullup,
	output logic             do_out,
	output logic             do_oe,
	output logic             do_pullup
);
	typedef struct packed {
		logic [7:0] shreg;
		logic       out_latch;
		logic [3:0] cnt;
		logic       f_start;
		logic       f_ovf;
		logic       f_stop;
		logic       start_hold;
		logic       sie;
		logic       oie;
		ssu_wm_type wm;
		ssu_cs_type cs;
		logic       clk_sel;
		logic [5:0] pins;
		logic       wreq;
		logic [7:0] rdata;
		logic       start_irq;
		logic       ovf_irq;
		logic [8:0] pad;
	} ssu_st_type;

	ssu_st_type s_r;
	ssu_st_type s_nxt;
	logic [1:0] rst_sync;
	logic       rst_sync_n;

	logic       req;
	logic       take;
	logic       wr;
	logic [1:0] sel;
	logic [7:0] wd;
	logic       clk_wr;
	logic       tc_wr;
	logic       sh_clk;
	logic       cnt_clk;
	logic       ovf_set;
	logic       start_set;
	logic       two;
	logic       do_val;
	logic       coll;
	logic [7:0] rd;

	ssu_pin_if pif ();

	// Set has priority over a write-one clear in the same cycle
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		flag_next = set | (cur & ~clr);
	endfunction : flag_next

	// Pin synchroniser and line event detector; inputs do not see wire mode
	ssu_pin_sync u_sync (
		.clk       (clk),
		.rst_n     (rst_sync_n),
		.clk_en    (clk_en),
		.scl_pin_i (scl_in),
		.sda_pin_i (sda_in),
		.pins      (pif.det)
	);

	// Reset release through two flops, assert stays asynchronous
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync[1];

	// Next-state logic for the whole block
	always_comb begin
		s_nxt  = s_r;
		req    = avs_read | avs_write;
		take   = req & ~s_r.wreq;
		wr     = take & avs_write;
		sel    = avs_address[3:2];
		wd     = avs_writedata[7:0];
		two    = s_r.wm[1];
		clk_wr = wr && sel == OFF_CONTROL[3:2] && wd[CT_CLK];
		tc_wr  = wr && sel == OFF_CONTROL[3:2] && wd[CT_TC];
		// Purely combinational compare, nothing remembered
		coll   = pif.sda_lvl ^ s_r.shreg[7];

		// Shift register clock per source field
		unique case (s_r.cs)
			CS_STROBE:  sh_clk = clk_wr;
			CS_TIMER:   sh_clk = timer_ovf;
			CS_EXT_POS: sh_clk = pif.scl_rise;
			CS_EXT_NEG: sh_clk = pif.scl_fall;
		endcase

		// Counter clock; external edges count regardless of wire mode
		if (!s_r.cs[1]) begin
			cnt_clk = sh_clk;
		end else if (s_r.clk_sel) begin
			cnt_clk = tc_wr;
		end else begin
			cnt_clk = pif.scl_rise | pif.scl_fall;
		end
		ovf_set = cnt_clk && s_r.cnt == CNT_MAX;

		// Start flag from detector, or outside two-wire from any clock line edge while those edges clock the counter
		start_set = two ? pif.start_det
			: (s_r.cs[1] & ~s_r.clk_sel & (pif.scl_rise | pif.scl_fall));

		// Internal clocks see the MSB directly, external ones the latch
		do_val = s_r.cs[1] ? s_r.out_latch : s_r.shreg[7];

		// Shift in the sampled data line
		if (sh_clk) begin
			s_nxt.shreg = {s_r.shreg[6:0], pif.sda_lvl};
		end
		// Output latch moves on the edge opposite to sampling
		if ((s_r.cs == CS_EXT_POS && pif.scl_fall) || (s_r.cs == CS_EXT_NEG && pif.scl_rise)) begin
			s_nxt.out_latch = s_r.shreg[7];
		end
		if (cnt_clk) begin
			s_nxt.cnt = 4'(s_r.cnt + 4'h1);
		end

		// Flags: hardware set wins over software clear
		s_nxt.f_start = flag_next(s_r.f_start, start_set,
			wr && sel == OFF_STATUS[3:2] && wd[ST_START]);
		s_nxt.f_ovf   = flag_next(s_r.f_ovf, ovf_set,
			wr && sel == OFF_STATUS[3:2] && wd[ST_OVF]);
		s_nxt.f_stop  = flag_next(s_r.f_stop, two & pif.stop_det,
			wr && sel == OFF_STATUS[3:2] && wd[ST_STOP]);

		// Start hold begins at the clock fall after a start, ends with the flag
		s_nxt.start_hold = s_nxt.f_start & two & (s_r.start_hold | pif.scl_fall);

		// Register writes; a bus write beats a shift or count
		if (wr) begin
			unique case (sel)
				OFF_STATUS[3:2]: s_nxt.cnt = wd[3:0];
				OFF_CONTROL[3:2]: begin
					s_nxt.sie     = wd[CT_SIE];
					s_nxt.oie     = wd[CT_OIE];
					s_nxt.wm      = ssu_wm_type'(wd[CT_WM_LO +: 2]);
					s_nxt.cs      = ssu_cs_type'(wd[CT_CS_LO +: 2]);
					s_nxt.clk_sel = wd[CT_CLK];
				end
				OFF_DATA[3:2]: s_nxt.shreg = wd;
				OFF_PINS[3:2]: s_nxt.pins = wd[5:0];
			endcase
		end
		// Toggle acts on the clock port value, whatever its direction
		if (tc_wr) begin
			s_nxt.pins[PN_SCL_PORT] = ~s_nxt.pins[PN_SCL_PORT];
		end

		// Read mux; strobe bits read zero
		unique case (sel)
			OFF_STATUS[3:2]:  rd = {s_r.f_start, s_r.f_ovf, s_r.f_stop, coll, s_r.cnt};
			OFF_CONTROL[3:2]: rd = {s_r.sie, s_r.oie, s_r.wm, s_r.cs, 2'b00};
			OFF_DATA[3:2]:    rd = s_r.shreg;
			OFF_PINS[3:2]:    rd = {2'b00, s_r.pins};
		endcase
		// One wait state: data captured as waitrequest drops
		s_nxt.wreq = ~(req & s_r.wreq);
		if (req && s_r.wreq) begin
			s_nxt.rdata = rd;
		end

		// Interrupt requests are levels; a pending flag fires at once
		s_nxt.start_irq = s_r.sie & global_irq_en & s_r.f_start;
		s_nxt.ovf_irq   = s_r.oie & global_irq_en & s_r.f_ovf;

		// Pin drivers; default is plain port behaviour
		s_nxt.pad    = 9'h000;
		s_nxt.pad[0] = s_r.pins[PN_DO_PORT];
		s_nxt.pad[1] = s_r.pins[PN_DO_DIR];
		s_nxt.pad[2] = ~s_r.pins[PN_DO_DIR] & s_r.pins[PN_DO_PORT];
		s_nxt.pad[3] = s_r.pins[PN_SDA_PORT];
		s_nxt.pad[4] = s_r.pins[PN_SDA_DIR];
		s_nxt.pad[5] = ~s_r.pins[PN_SDA_DIR] & s_r.pins[PN_SDA_PORT];
		s_nxt.pad[6] = s_r.pins[PN_SCL_PORT];
		s_nxt.pad[7] = s_r.pins[PN_SCL_DIR];
		s_nxt.pad[8] = ~s_r.pins[PN_SCL_DIR] & s_r.pins[PN_SCL_PORT];
		if (s_r.wm == WM_THREE) begin
			s_nxt.pad[0] = do_val;
		end else if (two) begin
			// Open-drain: only ever drive low
			s_nxt.pad[3] = 1'b0;
			s_nxt.pad[4] = s_r.pins[PN_SDA_DIR] & ~(do_val & s_r.pins[PN_SDA_PORT]);
			s_nxt.pad[5] = 1'b0;
			s_nxt.pad[6] = 1'b0;
			s_nxt.pad[7] = s_r.pins[PN_SCL_DIR] & (~s_r.pins[PN_SCL_PORT] | s_r.start_hold
				| (s_r.wm == WM_TWO_HOLD && s_r.f_ovf));
			s_nxt.pad[8] = 1'b0;
		end
	end

	// All state but the reset and pin synchronisers in one register, frozen while clk_en is low
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_r <= '{shreg: DATA_RST, out_latch: 1'b0, cnt: 4'h0, f_start: 1'b0,
				f_ovf: 1'b0, f_stop: 1'b0, start_hold: 1'b0,
				sie: CTRL_RST[CT_SIE], oie: CTRL_RST[CT_OIE], wm: WM_OFF,
				cs: CS_STROBE, clk_sel: CTRL_RST[CT_CLK], pins: PINS_RST,
				wreq: 1'b1, rdata: 8'h00, start_irq: 1'b0, ovf_irq: 1'b0,
				pad: 9'h000};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign avs_readdata    = {24'h000000, s_r.rdata};
	assign avs_waitrequest = s_r.wreq;
	assign start_irq       = s_r.start_irq;
	assign overflow_irq    = s_r.ovf_irq;
	assign do_out          = s_r.pad[0];
	assign do_oe           = s_r.pad[1];
	assign do_pullup       = s_r.pad[2];
	assign sda_out         = s_r.pad[3];
	assign sda_oe          = s_r.pad[4];
	assign sda_pullup      = s_r.pad[5];
	assign scl_out         = s_r.pad[6];
	assign scl_oe          = s_r.pad[7];
	assign scl_pullup      = s_r.pad[8];

	// Checks on the block's own behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	property p_stop_flag;
		clk_en && !s_r.f_stop && !(two && pif.stop_det) |=> !s_r.f_stop;
	endproperty
	a_stop_flag: assert property (p_stop_flag) else $error("stop flag set without stop");

	property p_cnt_read;
		clk_en && req && s_r.wreq && avs_read && sel == OFF_STATUS[3:2]
			|=> avs_readdata[3:0] == $past(s_r.cnt) && !avs_waitrequest;
	endproperty
	a_cnt_read: assert property (p_cnt_read) else $error("counter read mismatch");

	property p_cnt_inc;
		clk_en && cnt_clk && !wr |=> s_r.cnt == 4'($past(s_r.cnt) + 4'h1);
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step by one");

	property p_ovf_wrap;
		clk_en && cnt_clk && s_r.cnt == CNT_MAX && !wr |=> s_r.f_ovf && s_r.cnt == 4'h0;
	endproperty
	a_ovf_wrap: assert property (p_ovf_wrap) else $error("wrap did not set overflow");

	property p_start_irq;
		clk_en && s_r.sie && global_irq_en && s_r.f_start |=> start_irq;
	endproperty
	a_start_irq: assert property (p_start_irq) else $error("start request missing");

	property p_ovf_irq;
		clk_en && $past(clk_en) && overflow_irq
			|-> $past(s_r.oie && global_irq_en && s_r.f_ovf);
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request unjustified");

	property p_wm_off_sda;
		clk_en && s_r.wm == WM_OFF |=> sda_oe == $past(s_r.pins[PN_SDA_DIR])
			&& !scl_pullup == $past(!(s_r.pins[PN_SCL_PORT] && !s_r.pins[PN_SCL_DIR]));
	endproperty
	a_wm_off_sda: assert property (p_wm_off_sda) else $error("mode zero pins not plain");

	property p_ovf_hold;
		clk_en && s_r.wm == WM_TWO_HOLD && s_r.f_ovf && s_r.pins[PN_SCL_DIR] |=> scl_oe && !scl_out;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("clock not held after overflow");

	property p_two_pullup;
		clk_en && two |=> !sda_pullup && !scl_pullup && !sda_out;
	endproperty
	a_two_pullup: assert property (p_two_pullup) else $error("pull-up on in two-wire mode");

	property p_tc_toggle;
		clk_en && tc_wr |=> s_r.pins[PN_SCL_PORT] != $past(s_r.pins[PN_SCL_PORT]);
	endproperty
	a_tc_toggle: assert property (p_tc_toggle) else $error("toggle did not invert port");
endmodule : ssu_ctl

// ==== ssu_pin_if.sv ====
// Purpose: synchronised line levels and line events toward the control logic
// Assumes: all signals on the system clock
// Notes:   events are one-cycle pulses
interface ssu_pin_if;
	logic scl_lvl;
	logic sda_lvl;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	modport det (output scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det);
	modport ctl (input scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det);
endinterface : ssu_pin_if

// ==== ssu_pin_sync.sv ====
// Purpose: synchronise clock and data pins, find edges, start and stop
// Assumes: pins are asynchronous to clk
// Notes:   bit 1 of each vector is the clock line, bit 0 the data line
module ssu_pin_sync
	import ssu_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic scl_pin_i,
	input  wire logic sda_pin_i,
	ssu_pin_if.det    pins
);
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic [1:0] prev;
	} ssu_sync_type;

	ssu_sync_type s_r;
	ssu_sync_type s_nxt;

	// Two-stage synchroniser, then a history stage for edges
	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = {scl_pin_i, sda_pin_i};
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// Only the synced and history stages feed the detectors
	assign pins.scl_lvl   = s_r.sync[1];
	assign pins.sda_lvl   = s_r.sync[0];
	assign pins.scl_rise  = s_r.sync[1] & ~s_r.prev[1];
	assign pins.scl_fall  = ~s_r.sync[1] & s_r.prev[1];
	// Data moving while the clock line stays high
	assign pins.start_det = s_r.sync[1] & s_r.prev[1] & s_r.prev[0] & ~s_r.sync[0];
	assign pins.stop_det  = s_r.sync[1] & s_r.prev[1] & ~s_r.prev[0] & s_r.sync[0];
endmodule : ssu_pin_sync

// ==== ssu_pkg.sv ====
// Purpose: shared constants and types of the serial shift unit control block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes:   register data sits in bits 7..0, upper bits read as zero
package ssu_pkg;
	// Register byte offsets
	localparam logic [3:0] OFF_STATUS  = 4'h0;
	localparam logic [3:0] OFF_CONTROL = 4'h4;
	localparam logic [3:0] OFF_DATA    = 4'h8;
	localparam logic [3:0] OFF_PINS    = 4'hc;

	// Status fields
	localparam int ST_START = 7;
	localparam int ST_OVF   = 6;
	localparam int ST_STOP  = 5;
	localparam int ST_COLL  = 4;

	// Control fields
	localparam int CT_SIE   = 7;
	localparam int CT_OIE   = 6;
	localparam int CT_WM_LO = 4;
	localparam int CT_CS_LO = 2;
	localparam int CT_CLK   = 1;
	localparam int CT_TC    = 0;

	// Pin control fields: port value and direction per pin
	localparam int PN_DO_PORT  = 0;
	localparam int PN_DO_DIR   = 1;
	localparam int PN_SDA_PORT = 2;
	localparam int PN_SDA_DIR  = 3;
	localparam int PN_SCL_PORT = 4;
	localparam int PN_SCL_DIR  = 5;

	// Reset values and counter maximum
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [5:0] PINS_RST = 6'h00;
	localparam logic [3:0] CNT_MAX  = 4'hf;

	typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} ssu_wm_type;
	typedef enum logic [1:0] {CS_STROBE, CS_TIMER, CS_EXT_POS, CS_EXT_NEG} ssu_cs_type;
endpackage : ssu_pkg

// ==== testbench.sv ====
// Purpose: self-checking bench of the serial shift unit control block
// Assumes: one wait state per bus access, pins fed back through wired-AND
// Notes:   fixed waits only cover synchroniser latency
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ssu_pkg::*;
	logic        clk, rstn, avs_read, avs_write, avs_waitrequest, timer_ovf, global_irq_en;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, seed;
	logic        start_irq, overflow_irq, scl_in, scl_out, scl_oe, scl_pullup;
	logic        sda_in, sda_out, sda_oe, sda_pullup, do_out, do_oe, do_pullup;
	logic        run, sda_drv, clk_en;
	logic [7:0]  rv;
	int          fails, comparisons, cyc, edges, n;
	ssu_ctl i_ssu_ctl (.clk(clk), .rstn(rstn), .clk_en(clk_en), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.timer_ovf(timer_ovf), .global_irq_en(global_irq_en), .start_irq(start_irq),
		.overflow_irq(overflow_irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
		.scl_pullup(scl_pullup), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.sda_pullup(sda_pullup), .do_out(do_out), .do_oe(do_oe), .do_pullup(do_pullup));
	ssu_bus_model i_ssu_bus_model (.run(run), .sda_drv(sda_drv), .scl_oe(scl_oe),
		.scl_out(scl_out), .sda_oe(sda_oe), .sda_out(sda_out), .scl_line(scl_in),
		.sda_line(sda_in));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Edges seen on the clock line, both directions
	always @(scl_in) edges++;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic complete_run();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end
	task automatic idle(input int k);
		repeat (k) @(posedge clk);
	endtask : idle
	// Request held until waitrequest is sampled low
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : wr
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata[7:0];
		avs_read <= 1'b0;
		`CHK(d & m, e)
	endtask : chk_rd
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clk) timer_ovf <= 1'b1;
			@(posedge clk) timer_ovf <= 1'b0;
		end
	endtask : tick
	initial begin
		{rstn, avs_read, avs_write, timer_ovf, global_irq_en, run} = 6'h00;
		clk_en = 1'b1;
		avs_address = 4'h0;
		avs_writedata = 32'h00000000;
		sda_drv = 1'b1;
		seed = 32'h0000004f;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		idle(4);
		// Reset values and plain port pins
		chk_rd(OFF_CONTROL, 8'hff, 8'h00);
		chk_rd(OFF_STATUS, 8'h0f, 8'h00);
		wr(OFF_PINS, 8'h01);
		idle(3);
		`CHK({do_pullup, do_oe}, 2'b10)
		wr(OFF_PINS, 8'h03);
		idle(3);
		`CHK({do_out, do_oe, do_pullup}, 3'b110)
		// Counter written and read back
		for (int i = 0; i < 6; i++) begin
			rv = xs();
			wr(OFF_STATUS, {4'h0, rv[3:0]});
			chk_rd(OFF_STATUS, 8'h0f, {4'h0, rv[3:0]});
		end
		// Software strobe, wrap and overflow request
		wr(OFF_STATUS, 8'hee);
		wr(OFF_CONTROL, 8'h42);
		chk_rd(OFF_STATUS, 8'h0f, 8'h0f);
		global_irq_en <= 1'b1;
		wr(OFF_CONTROL, 8'h42);
		chk_rd(OFF_STATUS, 8'h4f, 8'h40);
		idle(2);
		`CHK(overflow_irq, 1'b1)
		global_irq_en <= 1'b0;
		idle(2);
		`CHK(overflow_irq, 1'b0)
		chk_rd(OFF_CONTROL, 8'hff, 8'h40);
		wr(OFF_STATUS, 8'h40);
		chk_rd(OFF_STATUS, 8'h40, 8'h00);
		// No clock with strobe clear, timer ignored
		wr(OFF_CONTROL, 8'h40);
		tick(2);
		chk_rd(OFF_STATUS, 8'h0f, 8'h00);
		// Timer overflow as clock
		wr(OFF_CONTROL, 8'h04);
		n = 1 + int'(xs() % 5);
		tick(n);
		chk_rd(OFF_STATUS, 8'h0f, 8'(n));
		// Clock enable low freezes the counter against timer pulses
		clk_en <= 1'b0;
		tick(2);
		clk_en <= 1'b1;
		chk_rd(OFF_STATUS, 8'h0f, 8'(n));
		// External clock, both edges, clock and data outputs off
		wr(OFF_STATUS, 8'he0);
		wr(OFF_CONTROL, 8'h08);
		edges = 0;
		run <= 1'b1;
		idle(40);
		run <= 1'b0;
		idle(20);
		chk_rd(OFF_STATUS, 8'h0f, {4'h0, 4'(edges)});
		// Toggle strobe clocks the counter and flips the clock port
		wr(OFF_STATUS, 8'he0);
		wr(OFF_CONTROL, 8'h0a);
		wr(OFF_CONTROL, 8'h0b);
		chk_rd(OFF_STATUS, 8'h0f, 8'h01);
		chk_rd(OFF_PINS, 8'h10, 8'h10);
		wr(OFF_CONTROL, 8'h0b);
		chk_rd(OFF_STATUS, 8'h0f, 8'h02);
		chk_rd(OFF_PINS, 8'h10, 8'h00);
		// Two-wire: start, collision, hold, stop
		wr(OFF_STATUS, 8'he0);
		wr(OFF_PINS, 8'h3c);
		wr(OFF_DATA, 8'h80);
		wr(OFF_CONTROL, 8'ha0);
		idle(3);
		`CHK({sda_pullup, scl_pullup}, 2'b00)
		`CHK(sda_in, 1'b1)
		global_irq_en <= 1'b1;
		sda_drv <= 1'b0;
		idle(8);
		`CHK(start_irq, 1'b1)
		chk_rd(OFF_STATUS, 8'h10, 8'h10);
		run <= 1'b1;
		idle(10);
		run <= 1'b0;
		idle(10);
		`CHK(scl_in, 1'b0)
		wr(OFF_STATUS, 8'h80);
		idle(6);
		`CHK(scl_in, 1'b1)
		`CHK(start_irq, 1'b0)
		sda_drv <= 1'b1;
		idle(8);
		chk_rd(OFF_STATUS, 8'h20, 8'h20);
		`CHK({start_irq, overflow_irq}, 2'b00)
		wr(OFF_STATUS, 8'h20);
		chk_rd(OFF_STATUS, 8'h20, 8'h00);
		wr(OFF_DATA, 8'h00);
		idle(3);
		`CHK(sda_in, 1'b0)
		wr(OFF_DATA, 8'hff);
		wr(OFF_PINS, 8'h38);
		idle(3);
		`CHK(sda_in, 1'b0)
		wr(OFF_PINS, 8'h3c);
		// Mode three holds the clock line after overflow
		// Start flag from the pulls above cleared, else its hold would arm
		wr(OFF_STATUS, 8'h8f);
		wr(OFF_CONTROL, 8'h32);
		idle(4);
		`CHK(scl_in, 1'b0)
		wr(OFF_STATUS, 8'h40);
		idle(4);
		`CHK(scl_in, 1'b1)
		// Three-wire data output follows the shift MSB at once
		wr(OFF_CONTROL, 8'h10);
		wr(OFF_PINS, 8'h02);
		wr(OFF_DATA, 8'h80);
		idle(3);
		`CHK({do_out, do_oe}, 2'b11)
		wr(OFF_DATA, 8'h7f);
		idle(3);
		`CHK(do_out, 1'b0)
		wr(OFF_PINS, 8'h01);
		idle(3);
		`CHK({do_oe, do_pullup}, 2'b01)
		complete_run();
	end
endmodule : testbench
